// File: tws_slave.sv
/*
 * two-wire bus slave: address match, receive with or without clock
 * stretch, transmit, start/stop detection, apb register file.
 * assumes: an external master drives scl; scl/sda are open drain and
 * resolved outside; pclk is much faster than scl.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tws_defines.svh"

module tws_slave
    import tws_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    tws_state_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q, rbuf_q, dbuf_q, tx_src;
    logic [6:0] own_q, alt_q;
    logic ie_q, handshake_enable_q, tsel_q, ack_evaluate_enable_q, stop_irq_mask_q;
    logic interrupt_request_flag_q, transfer_request_flag_q, rdf_q, tde_q, bus_busy_flag_q, stop_q, error_stop_flag_q, alternate_address_match_flag_q, ack_bit_q;
    logic pend_q, txv_q, scl_oe_q, sda_oe_q, scl_o_q, sda_o_q, irq_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_w;
    logic scl_s, scl_r, scl_f, sda_s, sda_r, sda_f;
    logic framing, start_ev, stop_ev, rise_ev, fall_ev, bit8, ev9, ack_fall, end9;
    logic acc, wr_ev, dat_rd, dat_wr, ctl_wr, own_hit, alt_hit, match8, tx_wait, move9;

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
        return a == AW'(ofs);
    endfunction

    tws_sync u_scl (.clk(pclk), .rst_n(presetn), .ce(ce), .din(scl_i),
        .lvl(scl_s), .rise(scl_r), .fall(scl_f));
    tws_sync u_sda (.clk(pclk), .rst_n(presetn), .ce(ce), .din(sda_i),
        .lvl(sda_s), .rise(sda_r), .fall(sda_f));

    // bus events, all qualified by the clock enable
    assign framing = (st_q == TWS_ADDR) || (st_q == TWS_RX) || (st_q == TWS_TX);
    assign start_ev = ce && sda_f && scl_s;
    assign stop_ev = ce && sda_r && scl_s;
    assign rise_ev = ce && scl_r && framing;
    assign fall_ev = ce && scl_f && framing;
    assign bit8 = rise_ev && (cnt_q == `TWS_ADDR_CLK);
    assign ev9 = rise_ev && (cnt_q == `TWS_ACK_CLK);
    assign ack_fall = fall_ev && (cnt_q == `TWS_ACK_CLK);
    assign end9 = fall_ev && (cnt_q == `TWS_LAST_CLK);
    assign own_hit = (sh_q[6:0] == own_q);
    assign alt_hit = (sh_q[6:0] == alt_q);
    assign match8 = bit8 && (st_q == TWS_ADDR) && (own_hit || alt_hit);
    assign tx_wait = (st_q == TWS_TX) && scl_oe_q;

    // apb access completes where pready is seen high
    assign acc = ce && psel && penable && pready_q;
    assign wr_ev = acc && pwrite;
    assign ctl_wr = wr_ev && hit(paddr, `TWS_OFS_CTRL);
    assign dat_rd = acc && !pwrite && hit(paddr, `TWS_OFS_DATA);
    assign dat_wr = wr_ev && hit(paddr, `TWS_OFS_DATA);
    // a write landing on the ninth rise goes straight to the shifter
    assign tx_src = dat_wr ? pwdata[7:0] : dbuf_q;
    assign move9 = ev9 && (st_q == TWS_TX) && (!tde_q || dat_wr);

    // read word assembly
    always_comb begin
        rd_w = 32'h0;
        if (hit(paddr, `TWS_OFS_CTRL)) begin
            rd_w[`TWS_CTRL_IE] = ie_q;
            rd_w[`TWS_CTRL_HANDSHAKE_ENABLE] = handshake_enable_q;
            rd_w[`TWS_CTRL_TSEL] = tsel_q;
            rd_w[`TWS_CTRL_ACK_EVALUATE_ENABLE] = ack_evaluate_enable_q;
            rd_w[`TWS_CTRL_STOP_IRQ_MASK] = stop_irq_mask_q;
        end else if (hit(paddr, `TWS_OFS_STAT)) begin
            rd_w[`TWS_ST_INTERRUPT_REQUEST_FLAG] = interrupt_request_flag_q;
            rd_w[`TWS_ST_TRANSFER_REQUEST_FLAG] = transfer_request_flag_q;
            rd_w[`TWS_ST_RDF] = rdf_q;
            rd_w[`TWS_ST_TDE] = tde_q;
            rd_w[`TWS_ST_BUSY] = bus_busy_flag_q;
            rd_w[`TWS_ST_STOP] = stop_q;
            rd_w[`TWS_ST_ERROR_STOP_FLAG] = error_stop_flag_q;
            rd_w[`TWS_ST_ALTERNATE_ADDRESS_MATCH_FLAG] = alternate_address_match_flag_q;
            rd_w[`TWS_ST_ACK_BIT] = ack_bit_q;
        end else if (hit(paddr, `TWS_OFS_ADDR)) begin
            rd_w[`TWS_OWN_MSB:`TWS_OWN_LSB] = own_q;
            rd_w[`TWS_ALT_MSB:`TWS_ALT_LSB] = alt_q;
        end else if (hit(paddr, `TWS_OFS_DATA)) begin
            rd_w[7:0] = rbuf_q;
        end
    end

    // apb slave: one wait-free access cycle, data snapped in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            pready_q <= psel && !penable;
            if (psel && !penable) begin
                prdata_q <= rd_w;
                pslverr_q <= !(hit(paddr, `TWS_OFS_CTRL) || hit(paddr, `TWS_OFS_STAT)
                    || hit(paddr, `TWS_OFS_ADDR) || hit(paddr, `TWS_OFS_DATA));
            end
        end
    end

    // frame sequencer and receive shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= TWS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
        end else if (ce) begin
            if (start_ev) begin
                st_q <= TWS_ADDR;
                cnt_q <= 4'h0;
            end else if (stop_ev) begin
                st_q <= TWS_IDLE;
                cnt_q <= 4'h0;
            end else begin
                if (rise_ev && cnt_q < `TWS_ACK_CLK)
                    sh_q <= {sh_q[6:0], sda_s};
                if (rise_ev)
                    cnt_q <= cnt_q + 4'h1;
                if (end9)
                    cnt_q <= 4'h0;
                // a mismatch parks the sequencer until the next start
                if (bit8 && st_q == TWS_ADDR && !own_hit && !alt_hit)
                    st_q <= TWS_IGN;
                else if (end9 && st_q == TWS_ADDR)
                    st_q <= tsel_q ? TWS_TX : TWS_RX;
                else if (dat_rd && tx_wait && !tsel_q)
                    st_q <= TWS_IGN;
            end
        end
    end

    // software control and slave addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= 1'b0;
            handshake_enable_q <= 1'b0;
            tsel_q <= 1'b0;
            ack_evaluate_enable_q <= 1'b0;
            stop_irq_mask_q <= 1'b0;
            own_q <= `TWS_OWN_RST;
            alt_q <= `TWS_ALT_RST;
        end else if (ce) begin
            if (ctl_wr) begin
                ie_q <= pwdata[`TWS_CTRL_IE];
                handshake_enable_q <= pwdata[`TWS_CTRL_HANDSHAKE_ENABLE];
                tsel_q <= pwdata[`TWS_CTRL_TSEL];
                ack_evaluate_enable_q <= pwdata[`TWS_CTRL_ACK_EVALUATE_ENABLE];
                stop_irq_mask_q <= pwdata[`TWS_CTRL_STOP_IRQ_MASK];
            end
            if (wr_ev && hit(paddr, `TWS_OFS_ADDR)) begin
                own_q <= pwdata[`TWS_OWN_MSB:`TWS_OWN_LSB];
                alt_q <= pwdata[`TWS_ALT_MSB:`TWS_ALT_LSB];
            end
            // the bus decides direction, over a same-cycle write
            if (match8)
                tsel_q <= sda_s;
        end
    end

    // flags and buffers; software clears first so hardware sets win, except the control-write wipe of ack_bit_q, which comes last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request_flag_q <= 1'b0;
            transfer_request_flag_q <= 1'b0;
            rdf_q <= 1'b0;
            tde_q <= 1'b0;
            bus_busy_flag_q <= 1'b0;
            stop_q <= 1'b0;
            error_stop_flag_q <= 1'b0;
            alternate_address_match_flag_q <= 1'b0;
            ack_bit_q <= 1'b0;
            pend_q <= 1'b0;
            rbuf_q <= 8'h00;
            dbuf_q <= 8'h00;
        end else if (ce) begin
            if (wr_ev && hit(paddr, `TWS_OFS_STAT)) begin
                if (pwdata[`TWS_ST_INTERRUPT_REQUEST_FLAG])
                    interrupt_request_flag_q <= 1'b0;
                if (pwdata[`TWS_ST_TRANSFER_REQUEST_FLAG])
                    transfer_request_flag_q <= 1'b0;
                if (pwdata[`TWS_ST_STOP])
                    stop_q <= 1'b0;
                if (pwdata[`TWS_ST_ERROR_STOP_FLAG])
                    error_stop_flag_q <= 1'b0;
                ack_bit_q <= pwdata[`TWS_ST_ACK_BIT];
            end
            if (start_ev)
                bus_busy_flag_q <= 1'b1;
            if (stop_ev) begin
                bus_busy_flag_q <= 1'b0;
                // every stop follows one scl rise; more rises mean a cut frame
                if (framing && cnt_q > 4'h1)
                    error_stop_flag_q <= 1'b1;
                else
                    stop_q <= 1'b1;
                if (!stop_irq_mask_q)
                    interrupt_request_flag_q <= 1'b1;
            end
            if (match8)
                alternate_address_match_flag_q <= !own_hit;
            if (dat_rd) begin
                rdf_q <= 1'b0;
                if (pend_q) begin
                    rbuf_q <= sh_q;
                    rdf_q <= 1'b1;
                    interrupt_request_flag_q <= 1'b1;
                    pend_q <= 1'b0;
                end
            end
            if (dat_wr) begin
                dbuf_q <= pwdata[7:0];
                tde_q <= 1'b0;
            end
            if (ev9) begin
                interrupt_request_flag_q <= 1'b1;
                if (alternate_address_match_flag_q)
                    transfer_request_flag_q <= 1'b1;
                if (st_q == TWS_TX) begin
                    ack_bit_q <= sda_s;
                    if (move9)
                        tde_q <= 1'b1;
                end else if (st_q == TWS_ADDR && tsel_q) begin
                    tde_q <= 1'b1;
                end else if (!rdf_q || dat_rd) begin
                    rbuf_q <= sh_q;
                    rdf_q <= 1'b1;
                end else begin
                    pend_q <= 1'b1; // held in the shifter until a read
                end
            end
            if (dat_wr && tx_wait) begin
                tde_q <= 1'b1;
                interrupt_request_flag_q <= 1'b1;
            end
            // writing zero to the evaluate enable wipes the stored ack
            if (ctl_wr && !pwdata[`TWS_CTRL_ACK_EVALUATE_ENABLE])
                ack_bit_q <= 1'b0;
        end
    end

    // pin drivers: sda only moves while scl is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            tx_q <= 8'h00;
            txv_q <= 1'b0;
        end else if (ce) begin
            if (start_ev || stop_ev) begin
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
            end else begin
                if (ack_fall) begin
                    case (st_q)
                        TWS_ADDR: sda_oe_q <= 1'b1;
                        TWS_RX: sda_oe_q <= !ack_bit_q;
                        default: sda_oe_q <= 1'b0;
                    endcase
                end
                if (fall_ev && st_q == TWS_TX && cnt_q != 4'h0 && cnt_q < `TWS_ACK_CLK) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    sda_oe_q <= !tx_q[6];
                end
                if (move9) begin
                    tx_q <= tx_src;
                    txv_q <= 1'b1;
                end else if (ev9) begin
                    txv_q <= 1'b0;
                end
                if (end9) begin
                    if (st_q == TWS_TX || (st_q == TWS_ADDR && tsel_q)) begin
                        sda_oe_q <= txv_q && !tx_q[7];
                        scl_oe_q <= !txv_q;
                    end else begin
                        sda_oe_q <= 1'b0;
                        // no stretch if the byte was already read
                        scl_oe_q <= handshake_enable_q && rdf_q && !dat_rd;
                    end
                end
                if (dat_rd && scl_oe_q && (st_q == TWS_RX || (tx_wait && !tsel_q)))
                    scl_oe_q <= 1'b0;
                if (dat_wr && tx_wait) begin
                    tx_q <= pwdata[7:0];
                    sda_oe_q <= !pwdata[7];
                    scl_oe_q <= 1'b0;
                end
            end
        end
    end

    // open-drain data levels are always low; interrupt output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_o_q <= 1'b0;
            sda_o_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (ce) begin
            scl_o_q <= 1'b0;
            sda_o_q <= 1'b0;
            irq_q <= interrupt_request_flag_q && ie_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_o = scl_o_q;
    assign scl_oe = scl_oe_q;
    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;

    // checks on the sequencer, flags and pins
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start_busy;
        start_ev |=> bus_busy_flag_q && st_q == TWS_ADDR && cnt_q == 4'h0;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not set busy and address phase");

    property p_dir_sel;
        match8 |=> tsel_q == $past(sda_s) && st_q == TWS_ADDR;
    endproperty
    a_dir_sel: assert property (p_dir_sel)
        else $error("direction bit not copied to transmit select");

    property p_ignore;
        bit8 && st_q == TWS_ADDR && !own_hit && !alt_hit |=> st_q == TWS_IGN [*2];
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("mismatched address not ignored");

    property p_ack_drive;
        ack_fall && st_q == TWS_RX |=> sda_oe_q != $past(ack_bit_q);
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("acknowledge level differs from ack bit");

    property p_irq_9th;
        ev9 && ie_q && !ctl_wr |=> interrupt_request_flag_q ##1 irq_q;
    endproperty
    a_irq_9th: assert property (p_irq_9th)
        else $error("ninth rise did not raise interrupt");

    property p_trq;
        ev9 && alternate_address_match_flag_q |=> transfer_request_flag_q;
    endproperty
    a_trq: assert property (p_trq)
        else $error("transfer request missing on alternate match");

    property p_rx_move;
        ev9 && st_q == TWS_RX && !rdf_q |=> rdf_q && rbuf_q == $past(sh_q);
    endproperty
    a_rx_move: assert property (p_rx_move)
        else $error("received byte not moved to buffer");

    property p_hold;
        st_q == TWS_RX && scl_oe_q && !dat_rd && !start_ev && !stop_ev |=> scl_oe_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("scl released before buffer read");

    property p_release;
        dat_rd && st_q == TWS_RX && !pend_q && !ev9 |=> !rdf_q && !scl_oe_q;
    endproperty
    a_release: assert property (p_release)
        else $error("buffer read did not clear full or free scl");

    property p_stop;
        stop_ev && !stop_irq_mask_q |=> !bus_busy_flag_q && (stop_q || error_stop_flag_q) && interrupt_request_flag_q;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop not flagged correctly");

    property p_pend;
        dat_rd && pend_q |=> rdf_q && interrupt_request_flag_q && !pend_q;
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending byte not moved on read");

    property p_tx_stall;
        end9 && (st_q == TWS_TX || (st_q == TWS_ADDR && tsel_q)) && !txv_q |=> scl_oe_q;
    endproperty
    a_tx_stall: assert property (p_tx_stall)
        else $error("transmit did not stretch with empty buffer");

    property p_ack_cap;
        ev9 && st_q == TWS_TX && !ctl_wr && !wr_ev |=> ack_bit_q == $past(sda_s);
    endproperty
    a_ack_cap: assert property (p_ack_cap)
        else $error("master acknowledge not captured");

    property p_ack_evaluate_enable_clr;
        ctl_wr && !pwdata[`TWS_CTRL_ACK_EVALUATE_ENABLE] |=> !ack_bit_q;
    endproperty
    a_ack_evaluate_enable_clr: assert property (p_ack_evaluate_enable_clr)
        else $error("ack bit not cleared with evaluate enable");

    c_rx_stretch: cover property (end9 && st_q == TWS_RX ##1 scl_oe_q);
    c_tx_frame: cover property (move9);
    c_stop_seen: cover property (stop_ev && bus_busy_flag_q);

endmodule // tws_slave

`default_nettype wire

// File: tws_defines.svh
/*
 * register offsets, field positions, reset values and frame counts of the
 * two-wire slave controller.
 * assumes: included by bare name by every file that needs a number.
 */
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// byte offsets on the apb register bus
`define TWS_OFS_CTRL 8'h00
`define TWS_OFS_STAT 8'h04
`define TWS_OFS_ADDR 8'h08
`define TWS_OFS_DATA 8'h0c

// control register fields
`define TWS_CTRL_IE 0
`define TWS_CTRL_HANDSHAKE_ENABLE 1
`define TWS_CTRL_TSEL 2
`define TWS_CTRL_ACK_EVALUATE_ENABLE 3
`define TWS_CTRL_STOP_IRQ_MASK 4

// status register fields
`define TWS_ST_INTERRUPT_REQUEST_FLAG 0
`define TWS_ST_TRANSFER_REQUEST_FLAG 1
`define TWS_ST_RDF 2
`define TWS_ST_TDE 3
`define TWS_ST_BUSY 4
`define TWS_ST_STOP 5
`define TWS_ST_ERROR_STOP_FLAG 6
`define TWS_ST_ALTERNATE_ADDRESS_MATCH_FLAG 7
`define TWS_ST_ACK_BIT 8

// address register fields and reset values (plain defaults)
`define TWS_OWN_LSB 0
`define TWS_OWN_MSB 6
`define TWS_ALT_LSB 8
`define TWS_ALT_MSB 14
`define TWS_OWN_RST 7'h2a
`define TWS_ALT_RST 7'h2b

// scl rising edges counted within one frame
`define TWS_ADDR_CLK 4'h7
`define TWS_ACK_CLK 4'h8
`define TWS_LAST_CLK 4'h9

`endif

// File: tws_pkg.sv
/*
 * types shared by the two-wire slave controller.
 * assumes: compiled before any module that imports it.
 */
package tws_pkg;

    // frame sequencer, gray steps idle -> addr -> rx -> tx
    typedef enum logic [2:0] {
        TWS_IDLE = 3'h0,
        TWS_ADDR = 3'h1,
        TWS_RX = 3'h3,
        TWS_TX = 3'h2,
        TWS_IGN = 3'h6
    } tws_state_e;

endpackage

// File: tws_sync.sv
/*
 * two-flop synchroniser for one bus line with edge pulses.
 * assumes: din is asynchronous to clk; the idle line level is high.
 */
`timescale 1ns/100ps
`default_nettype none

module tws_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic din,
    output logic lvl,
    output logic rise,
    output logic fall
);
    logic s1_q, s2_q, s3_q;

    // only s2 reads s1; edges come from s2 against s3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl = s2_q;
    assign rise = s2_q && !s3_q;
    assign fall = !s2_q && s3_q;

endmodule // tws_sync

`default_nettype wire

// File: tws_mst_model.sv
/*
 * behavioural two-wire bus master that clocks the slave under test.
 * assumes: scl/sda are open drain with pull-ups; clk is the 50 MHz bench clock.
 */
`timescale 1ns/100ps
`default_nettype none

module tws_mst_model (
    input wire logic clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output wire logic scl,
    output wire logic sda
);
    logic scl_pull = 1'b0;
    logic sda_pull = 1'b0;

    // wired-and with pull-ups, so a released line reads high
    assign scl = !(scl_pull || scl_oe);
    assign sda = !(sda_pull || sda_oe);

    // 4 pclk steps give a 13 pclk, 260 ns link clock period
    task automatic hp();
        repeat (4) @(posedge clk);
    endtask

    // high phase is timed only once the wire is really high (stretch)
    task automatic clk_hi();
        scl_pull <= 1'b0;
        @(posedge clk);
        while (scl !== 1'b1) @(posedge clk);
        hp();
    endtask

    task automatic clk_lo();
        scl_pull <= 1'b1;
        hp();
    endtask

    task automatic start();
        sda_pull <= 1'b1;
        hp();
        clk_lo();
    endtask

    task automatic stop();
        sda_pull <= 1'b1;
        hp();
        clk_hi();
        sda_pull <= 1'b0;
        hp();
    endtask

    // msb first, acknowledge sampled at the end of the ninth high phase
    task automatic tx_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull <= !d[i];
            hp();
            clk_hi();
            clk_lo();
        end
        sda_pull <= 1'b0;
        hp();
        clk_hi();
        ack = sda;
        clk_lo();
    endtask

    task automatic rx_byte(output logic [7:0] d, input logic nack);
        sda_pull <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            hp();
            clk_hi();
            d[i] = sda;
            clk_lo();
        end
        sda_pull <= !nack;
        hp();
        clk_hi();
        clk_lo();
    endtask
endmodule // tws_mst_model

`default_nettype wire

// File: tb_top.sv
/*
 * self-checking bench for the two-wire slave: apb driver, note queue,
 * read monitor and a behavioural bus master.
 * assumes: tws_pkg, tws_slave and tws_mst_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((ex) !== (got)) begin \
    err_count++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ce = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, ack;
    wire logic scl;
    wire logic sda;
    int err_count = 0;
    int compares = 0;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [32:0] e, m;
    logic [31:0] rnd = 32'hecf528ac;
    logic [7:0] d, q;

    initial forever #10 pclk = !pclk;

    tws_slave u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    tws_mst_model u_mst (.clk(pclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // the master holds everything until pready is seen at an access edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // note first, so the monitor always finds the matching expectation
    task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [32:0] ex);
        msk_q.push_back({1'b1, mk});
        exp_q.push_back(ex);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // results are taken at the access edge where pready is sampled
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK("prdata", e, {pslverr, prdata} & m)
        end
    end

    task automatic end_sim();
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // run should need about 1700 cycles; 20000 means a hang
    initial begin
        #400000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(8'h00, 32'hffffffff, 33'h0);
        rd(8'h04, 32'h1f7, 33'h0);
        rd(8'h08, 32'h7f7f, 33'h2b2a);
        rd(8'h10, 32'hffffffff, 33'h100000000);
        // handshake receive, own address, write direction
        apb(1'b1, 8'h00, 32'h03);
        u_mst.start();
        rd(8'h04, 32'h10, 33'h10);
        u_mst.tx_byte(8'h54, ack);
        `CHK("addr ack", 1'b0, ack)
        settle();
        `CHK("stretch", 1'b1, scl_oe)
        `CHK("pin levels", 2'b00, {scl_o, sda_o})
        `CHK("irq", 1'b1, irq)
        rd(8'h04, 32'h1f7, 33'h15);
        rd(8'h0c, 32'hff, 33'h54);
        settle();
        `CHK("release", 1'b0, scl_oe)
        rd(8'h04, 32'h04, 33'h0);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0];
            apb(1'b1, 8'h04, {23'h0, i[0], 8'h01});
            u_mst.tx_byte(d, ack);
            `CHK("data ack", i[0], ack)
            rd(8'h0c, 32'hff, {25'h0, d});
        end
        u_mst.stop();
        settle();
        rd(8'h04, 32'h37, 33'h21);
        apb(1'b1, 8'h04, 32'h63);
        // address mismatch leaves the bus alone
        u_mst.start();
        u_mst.tx_byte(8'h66, ack);
        `CHK("mismatch ack", 1'b1, ack)
        u_mst.tx_byte(rnd[15:8], ack);
        `CHK("ignored ack", 1'b1, ack)
        rd(8'h04, 32'h07, 33'h0);
        u_mst.stop();
        // alternate address
        u_mst.start();
        u_mst.tx_byte(8'h56, ack);
        rd(8'h04, 32'h87, 33'h87);
        rd(8'h0c, 32'hff, 33'h56);
        u_mst.stop();
        apb(1'b1, 8'h04, 32'h63);
        // slave transmit with acknowledge evaluation on
        apb(1'b1, 8'h00, 32'h0b);
        u_mst.start();
        u_mst.tx_byte(8'h55, ack);
        `CHK("read ack", 1'b0, ack)
        settle();
        `CHK("tx stretch", 1'b1, scl_oe)
        rd(8'h00, 32'h04, 33'h04);
        rd(8'h04, 32'h09, 33'h09);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0];
            apb(1'b1, 8'h0c, rnd);
            apb(1'b1, 8'h04, 32'h01);
            u_mst.rx_byte(q, i[0]);
            `CHK("tx byte", d, q)
            rd(8'h04, 32'h109, i ? 33'h109 : 33'h009);
        end
        apb(1'b1, 8'h00, 32'h03);
        rd(8'h04, 32'h100, 33'h0);
        rd(8'h0c, 32'h0, 33'h0);
        settle();
        `CHK("tx release", 1'b0, scl_oe)
        u_mst.stop();
        settle();
        rd(8'h04, 32'h30, 33'h20);
        apb(1'b1, 8'h04, 32'h63);
        // continuous receive, no stretch, interrupts disabled
        rd(8'h04, 32'h04, 33'h0);
        apb(1'b1, 8'h00, 32'h00);
        u_mst.start();
        u_mst.tx_byte(8'h54, ack);
        rd(8'h0c, 32'hff, 33'h54);
        rnd = lfsr(rnd);
        u_mst.tx_byte(rnd[7:0], ack);
        apb(1'b1, 8'h04, 32'h101);
        u_mst.tx_byte(rnd[15:8], ack);
        `CHK("last nack", 1'b1, ack)
        `CHK("no stretch", 1'b0, scl_oe)
        `CHK("irq off", 1'b0, irq)
        apb(1'b1, 8'h04, 32'h01);
        rd(8'h0c, 32'hff, {25'h0, rnd[7:0]});
        rd(8'h04, 32'h05, 33'h05);
        rd(8'h0c, 32'hff, {25'h0, rnd[15:8]});
        u_mst.stop();
        settle();
        rd(8'h04, 32'h70, 33'h20);
        settle();
        // a frozen block must miss a start made while the enable is low
        ce <= 1'b0;
        u_mst.start();
        ce <= 1'b1;
        rd(8'h04, 32'h10, 33'h0);
        u_mst.stop();
        settle();
        `CHK("notes left", 0, exp_q.size())
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
